// *** common/i2c_pkg.sv ***
// Purpose: constants and types of the bus controller
// Assumes: 8-bit registers
// Notes: offsets are register indexes
// Functional notes
// RQ1: byte received or due to send sets byte_done_flag; irq if enabled.
// RQ2: lost arbitration sets arbitration_lost_flag; irq if enabled.
// RQ3: unacknowledged address sets address_nack_flag; may interrupt.
// RQ4: master starts only on a free bus.
// RQ5: master_select rising gives START, master mode.
// RQ6: master_select falling gives STOP.
// RQ7: bit rate set by six-bit prescale field.
// RQ8: repeat_start_request then address write gives repeated START.
// RQ9: first byte after START: seven-bit address, direction bit.
// RQ10: matching slave pulls SDA low at ninth clock.
// RQ11: START on idle bus: SDA falls, SCL high.
// RQ12: STOP: SDA rises, SCL high; bus free.
// RQ13: SDA moves while SCL low, MSB first, nine clocks a byte.
// RQ14: receiver pulls SDA low at ninth clock.
// RQ15: declining slave leaves SDA high at ninth clock.
// RQ16: unacknowledged slave transmitter releases SDA.
// RQ17: slave releases the bus on STOP.
// RQ18: repeated START: START without STOP.
// RQ19: released SDA seen low loses arbitration; release SDA.
// RQ20: losing master turns slave, no STOP; flag set.
// RQ21: low time from SCL fall; high time once SCL high.
// RQ22: slave may hold SCL low; master waits.
// RQ23: data ack only with ack_drive_enable; address match always acked.
// RQ24: enable set resets engine two clocks later, three clocks.
// RQ25: lines only pulled low or released; bus level sampled.
package i2c_pkg;
    // register indexes
    localparam logic [2:0] REG_CTRL     = 3'h0;
    localparam logic [2:0] REG_STATUS   = 3'h1;
    localparam logic [2:0] REG_PRESCALE = 3'h2;
    localparam logic [2:0] REG_OWN_ADDR = 3'h3;
    localparam logic [2:0] REG_DATA     = 3'h4;
    // control fields
    localparam int CTL_EN    = 7;
    localparam int CTL_IEN   = 6;
    localparam int CTL_MSEL  = 5;
    localparam int CTL_ACK_DRIVE_ENABLE = 4;
    localparam int CTL_RSR   = 3;
    // status fields
    localparam int ST_BD     = 7;
    localparam int ST_AL     = 6;
    localparam int ST_AN     = 5;
    localparam int ST_BUSY   = 4;
    localparam int ST_MASTER = 3;
    localparam int ST_SLVSEL = 2;
    localparam int ST_TX     = 1;
    localparam int ST_ACK    = 0;
    // prescale and own address fields
    localparam int PRE_MSB   = 5;
    localparam int OWN_LSB   = 1;
    // reset values
    localparam logic [5:0] PRESCALE_RST = 6'h00;
    localparam logic [6:0] OWN_ADDR_RST = 7'h00;
    // timing counts
    localparam logic [11:0] PRE_UNIT_CYC = 12'h008;
    localparam logic [2:0]  SRST_DELAY   = 3'h2;
    localparam logic [2:0]  SRST_LEN     = 3'h3;
    // byte phases by SCL rises
    localparam logic [3:0]  BIT_ACK      = 4'h8;
    localparam logic [3:0]  BIT_DONE     = 4'h9;

    typedef enum logic [3:0] {
        M_IDLE  = 4'h0,
        M_START = 4'h1,
        M_LOW   = 4'h3,
        M_HIGH  = 4'h2,
        M_STOP1 = 4'h6,
        M_STOP2 = 4'h7,
        M_RS1   = 4'h5,
        M_RS2   = 4'h4
    } mst_state_e;
endpackage : i2c_pkg

// *** hw/bus_line_monitor.sv ***
// Purpose: SCL edge, START and STOP detector
// Assumes: lines synchronous to core clock
// Notes: one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module bus_line_monitor (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic nrst_in,
    // bus levels
    input  wire logic scl_in,
    input  wire logic sda_in,
    // events
    output logic      scl_rise_out,
    output logic      scl_fall_out,
    output logic      start_det_out,
    output logic      stop_det_out
);
    typedef struct packed {
        logic scl;
        logic sda;
    } line_s;

    line_s s_r;
    line_s s_nxt;

    always_comb begin
        s_nxt         = '{scl: scl_in, sda: sda_in};
        scl_rise_out  = ~s_r.scl & scl_in;
        scl_fall_out  = s_r.scl & ~scl_in;
        start_det_out = s_r.scl & scl_in & s_r.sda & ~sda_in;
        stop_det_out  = s_r.scl & scl_in & ~s_r.sda & sda_in;
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_r <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : bus_line_monitor
`default_nettype wire

// *** hw/bit_clock_gen.sv ***
// Purpose: half-bit timer of the bus clock
// Assumes: restart starts a half period
// Notes: tick (pre+1)*unit+1 cycles after restart
`timescale 1ns/1ns
`default_nettype none
module bit_clock_gen (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       nrst_in,
    // control
    input  wire logic [5:0] prescale_in,
    input  wire logic       restart_in,
    // timing
    output logic            tick_out
);
    import i2c_pkg::*;

    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } tmr_s;

    tmr_s s_r;
    tmr_s s_nxt;

    function automatic logic [11:0] half_limit(input logic [5:0] pre);
        half_limit = 12'((12'(pre) + 12'h001) * PRE_UNIT_CYC - 12'h001);
    endfunction : half_limit

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (restart_in) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= half_limit(prescale_in)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1; // RQ7
        end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
        end
        tick_out = s_r.tick;
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : bit_clock_gen
`default_nettype wire

// *** hw/i2c_master_slave_protocol.sv ***
// Purpose: two-wire bus controller, master or slave
// Assumes: one-cycle strobes, never together
// Notes: open-drain lines
`timescale 1ns/1ns
`default_nettype none
module i2c_master_slave_protocol (
    // clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 nrst_in,
    // register port
    input  wire logic [2:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic      [7:0]           reg_rdata_out,
    // bus clock line
    input  wire logic                 scl_in,
    output logic                      scl_out,
    output logic                      scl_oe_out,
    // bus data line
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_out,
    // interrupt request
    output logic                      irq_out
);
    import i2c_pkg::*;

    typedef struct packed {
        logic       en;
        logic       irq_enable;
        logic       msel;
        logic       ack_drive_enable;
        logic       rsr;
        logic [5:0] pre;
        logic [6:0] own;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic       bd;
        logic       al;
        logic       an;
        logic       busy;
        logic       master;
        logic       slv_sel;
        logic       tx;
        logic       ack_rx;
        logic       start_req;
        logic       stop_req;
        logic       rs_req;
        logic       xfer;
        logic       first;
        logic       hold;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        mst_state_e mst;
        logic       scl_oe;
        logic       sda_oe;
        logic       irq;
        logic [7:0] rdata;
        logic [2:0] srst_cnt;
        logic       srst;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic tick;
    logic tmr_restart;
    logic addr_hit;

    bus_line_monitor u_mon (
        .core_clk_in   (core_clk_in),
        .nrst_in       (nrst_in),
        .scl_in        (scl_in),
        .sda_in        (sda_in),
        .scl_rise_out  (scl_rise),
        .scl_fall_out  (scl_fall),
        .start_det_out (start_det),
        .stop_det_out  (stop_det)
    );

    bit_clock_gen u_bclk (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .prescale_in (s_r.pre),
        .restart_in  (tmr_restart),
        .tick_out    (tick)
    );

    always_comb begin
        s_nxt       = s_r;
        tmr_restart = 1'b0;
        addr_hit    = ~s_r.master & (s_r.shift[7:1] == s_r.own);
        s_nxt.rdata = 8'h00;

        // soft reset after enable
        if (s_r.srst_cnt != 3'h0) begin
            if (s_r.srst_cnt == SRST_DELAY + SRST_LEN) begin
                s_nxt.srst_cnt = 3'h0;
            end else begin
                s_nxt.srst_cnt = s_r.srst_cnt + 3'h1;
            end
        end

        // register writes
        if (reg_wr_in) begin
            if (reg_addr_in == REG_CTRL) begin
                if (reg_wdata_in[CTL_EN] & ~s_r.en) begin
                    s_nxt.srst_cnt = 3'h1; // RQ24
                end
                s_nxt.en    = reg_wdata_in[CTL_EN];
                s_nxt.irq_enable   = reg_wdata_in[CTL_IEN];
                s_nxt.ack_drive_enable = reg_wdata_in[CTL_ACK_DRIVE_ENABLE];
                s_nxt.rsr   = reg_wdata_in[CTL_RSR];
                s_nxt.msel  = reg_wdata_in[CTL_MSEL];
                if (reg_wdata_in[CTL_MSEL] & ~s_r.msel) begin
                    s_nxt.start_req = 1'b1; // RQ5
                end
                if (~reg_wdata_in[CTL_MSEL]) begin
                    s_nxt.start_req = 1'b0;
                    if (s_r.msel & s_r.master) begin
                        s_nxt.stop_req = 1'b1; // RQ6
                    end
                end
            end else if (reg_addr_in == REG_STATUS) begin
                // write one to clear; set wins
                if (reg_wdata_in[ST_BD]) begin
                    s_nxt.bd = 1'b0;
                end
                if (reg_wdata_in[ST_AL]) begin
                    s_nxt.al = 1'b0;
                end
                if (reg_wdata_in[ST_AN]) begin
                    s_nxt.an = 1'b0;
                end
            end else if (reg_addr_in == REG_PRESCALE) begin
                s_nxt.pre = reg_wdata_in[PRE_MSB:0]; // RQ7
            end else if (reg_addr_in == REG_OWN_ADDR) begin
                s_nxt.own = reg_wdata_in[7:OWN_LSB];
            end else if (reg_addr_in == REG_DATA) begin
                s_nxt.txd = reg_wdata_in;
                s_nxt.bd  = 1'b0;
                if (s_r.rsr & s_r.master & s_r.hold) begin
                    s_nxt.rs_req = 1'b1; // RQ8
                    s_nxt.rsr    = 1'b0;
                end else if (s_r.hold & s_r.tx) begin
                    s_nxt.shift  = reg_wdata_in;
                    s_nxt.sda_oe = ~reg_wdata_in[7]; // RQ13
                    s_nxt.hold   = 1'b0;
                end
            end
        end

        // reads, data next cycle only
        if (reg_rd_in) begin
            if (reg_addr_in == REG_CTRL) begin
                s_nxt.rdata = {s_r.en, s_r.irq_enable, s_r.msel, s_r.ack_drive_enable, s_r.rsr, 3'h0};
            end else if (reg_addr_in == REG_STATUS) begin
                s_nxt.rdata = {s_r.bd, s_r.al, s_r.an, s_r.busy,
                               s_r.master, s_r.slv_sel, s_r.tx, s_r.ack_rx};
            end else if (reg_addr_in == REG_PRESCALE) begin
                s_nxt.rdata = {2'h0, s_r.pre};
            end else if (reg_addr_in == REG_OWN_ADDR) begin
                s_nxt.rdata = {s_r.own, 1'b0};
            end else if (reg_addr_in == REG_DATA) begin
                s_nxt.rdata = s_r.rxd;
                s_nxt.bd    = 1'b0;
                if (s_r.hold & ~s_r.tx & ~s_r.rs_req & ~s_r.stop_req) begin
                    s_nxt.hold = 1'b0;
                end
            end
        end

        // bus conditions
        if (start_det) begin
            s_nxt.busy    = 1'b1; // RQ11
            s_nxt.xfer    = 1'b1;
            s_nxt.first   = 1'b1; // RQ9
            s_nxt.bitcnt  = 4'h0;
            s_nxt.slv_sel = 1'b0;
            s_nxt.hold    = 1'b0;
            s_nxt.tx      = s_r.master;
            if (s_r.master) begin
                s_nxt.shift = s_r.txd;
            end
        end
        if (stop_det) begin
            s_nxt.busy    = 1'b0; // RQ12
            s_nxt.xfer    = 1'b0;
            s_nxt.slv_sel = 1'b0;
            s_nxt.hold    = 1'b0;
            s_nxt.tx      = 1'b0;
            if (~s_r.master) begin
                s_nxt.sda_oe = 1'b0; // RQ17
            end
        end

        // sample on SCL rise
        if (s_r.xfer & scl_rise) begin
            if (s_r.bitcnt < BIT_ACK) begin
                s_nxt.shift  = {s_r.shift[6:0], sda_in}; // RQ13
                s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                if (s_r.master & s_r.tx & s_r.shift[7] & ~sda_in) begin
                    // another master wins
                    s_nxt.al     = 1'b1; // RQ2
                    s_nxt.master = 1'b0; // RQ19
                    s_nxt.tx     = 1'b0;
                    s_nxt.mst    = M_IDLE; // RQ20
                    s_nxt.scl_oe = 1'b0;
                    s_nxt.sda_oe = 1'b0;
                end
            end else if (s_r.bitcnt == BIT_ACK) begin
                s_nxt.ack_rx = ~sda_in;
                s_nxt.bitcnt = BIT_DONE;
            end
        end

        // SDA moves after SCL fall
        if (s_r.xfer & scl_fall) begin
            if (s_r.bitcnt == BIT_ACK) begin
                if (s_r.tx) begin
                    s_nxt.sda_oe = 1'b0;
                end else if (s_r.first) begin
                    s_nxt.sda_oe = addr_hit; // RQ10
                end else begin
                    // data byte: SDA pulled low only with ack_drive_enable, else released
                    s_nxt.sda_oe = s_r.ack_drive_enable & (s_r.master | s_r.slv_sel); // RQ23 RQ14 RQ15
                end
            end else if (s_r.bitcnt == BIT_DONE) begin
                s_nxt.sda_oe = 1'b0;
                s_nxt.bitcnt = 4'h0;
                if (s_r.first) begin
                    s_nxt.first = 1'b0;
                    if (s_r.master) begin
                        s_nxt.hold = 1'b1;
                        if (s_r.ack_rx) begin
                            s_nxt.tx = ~s_r.shift[0];
                            s_nxt.bd = ~s_r.shift[0]; // RQ1
                        end else begin
                            s_nxt.an = 1'b1; // RQ3
                        end
                    end else if (addr_hit) begin
                        s_nxt.slv_sel = 1'b1;
                        s_nxt.tx      = s_r.shift[0];
                        s_nxt.hold    = s_r.shift[0];
                        s_nxt.bd      = s_r.shift[0]; // RQ1
                    end else begin
                        s_nxt.xfer = 1'b0;
                    end
                end else if (s_r.tx) begin
                    if (s_r.ack_rx) begin
                        s_nxt.bd   = 1'b1; // RQ1
                        s_nxt.hold = 1'b1;
                    end else if (s_r.master) begin
                        s_nxt.hold = 1'b1;
                    end else begin
                        s_nxt.tx   = 1'b0; // RQ16
                        s_nxt.xfer = 1'b0;
                    end
                end else begin
                    s_nxt.rxd  = s_r.shift;
                    s_nxt.bd   = 1'b1; // RQ1
                    s_nxt.hold = 1'b1;
                end
            end else if (s_r.tx) begin
                s_nxt.sda_oe = ~s_r.shift[7]; // RQ13
            end
        end

        // master clock and conditions
        case (s_r.mst)
            M_IDLE: begin
                if (s_r.start_req & s_r.en & ~s_r.busy & scl_in & sda_in) begin // RQ4
                    s_nxt.start_req = 1'b0;
                    s_nxt.master    = 1'b1;
                    s_nxt.sda_oe    = 1'b1; // RQ11
                    s_nxt.mst       = M_START;
                    tmr_restart     = 1'b1;
                end
            end
            M_START: begin
                if (tick) begin
                    s_nxt.scl_oe = 1'b1;
                    s_nxt.mst    = M_LOW;
                    tmr_restart  = 1'b1;
                end
            end
            M_LOW: begin
                if (s_r.stop_req) begin
                    s_nxt.stop_req = 1'b0;
                    s_nxt.hold     = 1'b0;
                    s_nxt.sda_oe   = 1'b1; // RQ6
                    s_nxt.mst      = M_STOP1;
                    tmr_restart    = 1'b1;
                end else if (s_r.rs_req) begin
                    s_nxt.rs_req = 1'b0;
                    s_nxt.hold   = 1'b0;
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.mst    = M_RS1; // RQ18
                    tmr_restart  = 1'b1;
                end else if (tick & ~s_r.hold) begin
                    s_nxt.scl_oe = 1'b0;
                    s_nxt.mst    = M_HIGH;
                    tmr_restart  = 1'b1;
                end
            end
            M_HIGH: begin
                if (~scl_in) begin
                    // stretched or pulled low early
                    tmr_restart = 1'b1; // RQ21 RQ22
                    if (scl_fall) begin
                        s_nxt.scl_oe = 1'b1;
                        s_nxt.mst    = M_LOW;
                    end
                end else if (tick) begin
                    s_nxt.scl_oe = 1'b1;
                    s_nxt.mst    = M_LOW;
                    tmr_restart  = 1'b1;
                end
            end
            M_STOP1: begin
                if (tick) begin
                    s_nxt.scl_oe = 1'b0;
                    s_nxt.mst    = M_STOP2;
                    tmr_restart  = 1'b1;
                end
            end
            M_STOP2: begin
                if (~scl_in) begin
                    tmr_restart = 1'b1; // RQ21
                end else if (tick) begin
                    s_nxt.sda_oe = 1'b0; // RQ12
                    s_nxt.master = 1'b0;
                    s_nxt.mst    = M_IDLE;
                end
            end
            M_RS1: begin
                if (tick) begin
                    s_nxt.scl_oe = 1'b0;
                    s_nxt.mst    = M_RS2;
                    tmr_restart  = 1'b1;
                end
            end
            M_RS2: begin
                if (~scl_in) begin
                    tmr_restart = 1'b1; // RQ21
                end else if (tick) begin
                    s_nxt.sda_oe = 1'b1; // RQ18
                    s_nxt.mst    = M_START;
                    tmr_restart  = 1'b1;
                end
            end
            default: begin
                s_nxt.mst = M_IDLE;
            end
        endcase

        // selected slave stretches SCL
        if (~s_nxt.master) begin
            s_nxt.scl_oe = s_nxt.hold & s_nxt.slv_sel; // RQ22
        end

        s_nxt.srst = (s_nxt.srst_cnt > SRST_DELAY); // RQ24
        if (s_nxt.srst | ~s_nxt.en) begin
            s_nxt.mst       = M_IDLE;
            s_nxt.master    = 1'b0;
            s_nxt.xfer      = 1'b0;
            s_nxt.hold      = 1'b0;
            s_nxt.slv_sel   = 1'b0;
            s_nxt.busy      = 1'b0;
            s_nxt.tx        = 1'b0;
            s_nxt.bitcnt    = 4'h0;
            s_nxt.start_req = 1'b0;
            s_nxt.stop_req  = 1'b0;
            s_nxt.rs_req    = 1'b0;
            s_nxt.scl_oe    = 1'b0;
            s_nxt.sda_oe    = 1'b0;
        end

        s_nxt.irq = s_nxt.irq_enable & (s_nxt.bd | s_nxt.al | s_nxt.an); // RQ1 RQ2 RQ3
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_r     <= '0;
            s_r.pre <= PRESCALE_RST;
            s_r.own <= OWN_ADDR_RST;
            s_r.mst <= M_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // open drain: only enables move
    always_comb begin
        scl_out       = 1'b0; // RQ25
        sda_out       = 1'b0;
        scl_oe_out    = s_r.scl_oe;
        sda_oe_out    = s_r.sda_oe;
        irq_out       = s_r.irq;
        reg_rdata_out = s_r.rdata;
    end
endmodule : i2c_master_slave_protocol
`default_nettype wire

// *** sim/i2c_monitor.sv ***
// Purpose: port checker
// Assumes: wired-AND lines
// Notes: bound to the top
`timescale 1ns/1ns
`default_nettype none
module i2c_monitor (
    input wire logic       core_clk_in,
    input wire logic       nrst_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe_out,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       irq_out
);
    import i2c_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic ctl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
    AST_PINS_LOW: assert property (!scl_out && !sda_out) else $error("pin value high");
    AST_START_IDLE: assert property ($rose(sda_oe_out) && $past(scl_in) && scl_in
        |-> $past(sda_in)) else $error("start on low data line");
    AST_HIGH_TIME: assert property ($rose(scl_oe_out) && $past(scl_in)
        |-> $past(scl_in, 4)) else $error("clock high too short");
    AST_LOW_TIME: assert property ($fell(scl_oe_out) |-> !$past(scl_in, 4))
        else $error("clock low too short");
    AST_DISABLE: assert property (ctl_wr && !reg_wdata_in[CTL_EN]
        |-> ##3 !scl_oe_out && !sda_oe_out) else $error("lines held while off");
    AST_IRQ_MASK: assert property (ctl_wr && !reg_wdata_in[CTL_IEN] |-> ##2 !irq_out)
        else $error("irq while masked");
    AST_UNMAP: assert property (reg_rd_in && reg_addr_in > REG_DATA
        |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    AST_STOP_FREE: assert property ($fell(sda_oe_out) && $past(scl_in) && scl_in
        |-> !scl_oe_out) else $error("stop with clock held");
endmodule : i2c_monitor
bind i2c_master_slave_protocol i2c_monitor i2c_monitor_i (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));
`default_nettype wire

// *** sim/bus_peer.sv ***
// Purpose: far-side slave receiver
// Assumes: core clock sampling
// Notes: stretches SCL after its bytes
`timescale 1ns/1ns
`default_nettype none
module bus_peer #(
    parameter logic [6:0] ADDR    = 7'h5A,
    parameter int         STRETCH = 24
) (
    input  wire logic       clk_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_pull_out,
    output logic            sda_pull_out,
    output logic [7:0]      byte_out,
    output int              stops_out
);
    logic       sp = 1'b1;
    logic       dp = 1'b1;
    logic       first = 1'b0;
    logic       sel = 1'b0;
    logic [7:0] sh = 8'h00;
    int         nb = 0;
    int         hold = 0;
    initial {scl_pull_out, sda_pull_out, stops_out, byte_out} = '0;
    always @(posedge clk_in) begin
        sp <= scl_in;
        dp <= sda_in;
        if (hold > 0) hold <= hold - 1;
        else scl_pull_out <= 1'b0;
        if (sp && scl_in && dp && !sda_in) begin
            nb <= 0;
            first <= 1'b1;
        end else if (sp && scl_in && !dp && sda_in) begin
            sel <= 1'b0;
            sda_pull_out <= 1'b0;
            stops_out <= stops_out + 1;
        end else if (!sp && scl_in) begin
            sh <= {sh[6:0], sda_in};
            nb <= nb + 1;
        end else if (sp && !scl_in && nb == 8) begin
            sel <= first ? sh[7:1] == ADDR && !sh[0] : sel;
            sda_pull_out <= first ? sh[7:1] == ADDR : sel;
            byte_out <= sh;
            nb <= 9;
        end else if (sp && !scl_in && nb == 10) begin
            sda_pull_out <= 1'b0;
            first <= 1'b0;
            nb <= 0;
            scl_pull_out <= sel;
            hold <= STRETCH;
        end
    end
endmodule : bus_peer
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: self-checking bench, device as master
// Assumes: pull-ups on both lines
// Notes: queue model of peer bytes
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import i2c_pkg::*;
    localparam logic [6:0] PEER = 7'h5A;
    logic       core_clk_in, nrst_in, reg_wr_in, reg_rd_in;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, got, d, pb;
    logic       scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, p_scl, p_sda;
    wire logic  scl_in = !(scl_oe_out || p_scl);
    wire logic  sda_in = !(sda_oe_out || p_sda);
    int         failures = 0, check_count = 0, cyc = 0, stops, seed = 66607;
    logic [7:0] q[$];
    i2c_master_slave_protocol i2c_master_slave_protocol_i (.core_clk_in(core_clk_in),
        .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));
    bus_peer #(.ADDR(PEER)) bus_peer_i (.clk_in(core_clk_in), .scl_in(scl_in),
        .sda_in(sda_in), .scl_pull_out(p_scl), .sda_pull_out(p_sda), .byte_out(pb),
        .stops_out(stops));
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = !core_clk_in;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= w;
        reg_rd_in <= !w;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1 got = reg_rdata_out;
        @(posedge core_clk_in);
    endtask : acc
    task automatic wait_irq();
        repeat (3) @(posedge core_clk_in);
        for (int n = 0; n < 4000 && irq_out !== 1'b1; n++) @(posedge core_clk_in);
        chk("irq", {7'h00, irq_out}, 8'h01);
    endtask : wait_irq
    always @(posedge core_clk_in) if (++cyc == 60000) begin
        failures++;
        final_report();
    end
    initial begin
        {nrst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        repeat (4) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(posedge core_clk_in);
        acc(1'b1, REG_CTRL, 8'h00);
        acc(1'b1, REG_PRESCALE, rnd() & 8'h03);
        acc(1'b1, REG_OWN_ADDR, 8'h44);
        acc(1'b1, REG_CTRL, 8'hD0);
        repeat (8) @(posedge core_clk_in);
        acc(1'b0, REG_STATUS, 8'h00);
        chk("idle", got & 8'h18, 8'h00);
        q.push_back({PEER, 1'b0});
        acc(1'b1, REG_DATA, {PEER, 1'b0});
        acc(1'b1, REG_CTRL, 8'hF0);
        wait_irq();
        acc(1'b0, REG_STATUS, 8'h00);
        chk("master", got & 8'h38, 8'h18);
        chk("address", pb, q.pop_front());
        repeat (2) begin
            d = rnd();
            q.push_back(d);
            acc(1'b1, REG_DATA, d);
            wait_irq();
            chk("data", pb, q.pop_front());
        end
        $display("test write done");
        acc(1'b1, REG_CTRL, 8'hF8);
        acc(1'b1, REG_DATA, 8'h22);
        wait_irq();
        acc(1'b0, REG_STATUS, 8'h00);
        chk("nack", got & 8'h38, 8'h38);
        chk("no stop", 8'(stops), 8'h00);
        $display("test restart done");
        acc(1'b1, REG_STATUS, 8'hE0);
        acc(1'b1, REG_CTRL, 8'hD0);
        repeat (300) @(posedge core_clk_in);
        chk("stop", 8'(stops), 8'h01);
        acc(1'b0, REG_STATUS, 8'h00);
        chk("free", got & 8'h18, 8'h00);
        acc(1'b0, 3'h7, 8'h00);
        chk("unmapped", got, 8'h00);
        $display("test stop done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
